// ===== hdl/cvc_pkg.sv
// Constants and carrier types for the convolver cascade configuration block
// Functional notes
// - Standalone device drives register-load-select high during a load sequence.
// - Interlaced use: bypass input marks odd/even field and steers line-store routing.
// - Coefficients load after reset and, outside host mode, reload on each load trigger.
// - Open host-mode strap selects host mode; host supplies strobe and read/write.
// - Low eight expansion pins form a two-way host data bus.
// - Device acknowledges host on reply-chain-out; host may skip it with long strobes.
// - Register A bits 6:4 pick window mode; 3:0 ignored standalone, 7 with gain.
// - Register C bits 5:4 pick result field, bottom or four bits up.
// - Gain puts 16 top result bits out; overflow flag rises on overflow.
// - Register B bits 2:1 pick line length method; bit 3 external delay.
// - Line-store delay field 01 delays line-store inputs by four pixels.
// - Register D bit 1 shifts internal sum left eight before expansion add.
// - Register D bit 0 adds four accepted pixels of delay on expansion input.
// - Line-store delay field 11 delays line-store inputs by twelve pixels.
package cvc_pkg;
  localparam int CLK_PERIOD_NS    = 25;
  localparam int EPROM_ACCESS_NS  = 250;
  localparam int EPROM_WAIT_CYC   = (EPROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REPLY_MAX_NS     = 50;
  localparam int REPLY_MAX_CYC    = (REPLY_MAX_NS / CLK_PERIOD_NS < 1) ? 1 : REPLY_MAX_NS / CLK_PERIOD_NS;
  localparam int LOAD_WORDS       = 8;
  localparam logic [2:0] IDX_REG_A = 3'h0;
  localparam logic [2:0] IDX_REG_B = 3'h1;
  localparam logic [2:0] IDX_REG_C = 3'h2;
  localparam logic [2:0] IDX_REG_D = 3'h3;
  localparam logic [7:0] RST_REG   = 8'h00;
  localparam int A_MODE_LSB  = 4;
  localparam int A_GAINX_BIT = 7;
  localparam int B_LEN_LSB   = 1;
  localparam int B_EXTD_BIT  = 3;
  localparam int C_FIELD_LSB = 4;
  localparam int C_GAIN_LSB  = 0;
  localparam int D_EXPD_BIT  = 0;
  localparam int D_SHIFT_BIT = 1;
  localparam int D_LSD_LSB   = 2;
  localparam int LSD_STEP    = 4;
  localparam int LSD_DEPTH   = 12;
  localparam int EXP_DELAY   = 4;
  localparam int SUM_SHIFT   = 8;
  localparam int FIELD_W     = 20;
  localparam int FIELD_STEP  = 4;
  localparam int RESULT_W    = 16;
  localparam int FIFO_DEPTH  = 8;
  typedef struct packed {
    logic [2:0] window_mode;
    logic [3:0] cascade_bits;
    logic       gain_ext_bit;
    logic [1:0] line_len_mode;
    logic       ext_delay_comp;
  } cvc_cfg_t;
  typedef struct packed {
    logic                ovf;
    logic [RESULT_W-1:0] data;
  } cvc_result_t;
endpackage : cvc_pkg

// ===== hdl/cvc_core.sv
// Result FIFO and configuration, loading and cascade datapath of the convolver
`timescale 1ns/1ps
`default_nettype none
module cvc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("cvc_fifo depth must be a power of two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } cvc_fifo_st_t;
  cvc_fifo_st_t s, next_s;
  logic push, pop;
  assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp        = s.wp + 1'b1;
    end
    if (pop) next_s.rp = s.rp + 1'b1;
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) s <= '0;
    else if (clk_en) s <= next_s;
  end
endmodule : cvc_fifo

////////////////////////////////////////////////////////////////////////////////
module cvc_top #(
  parameter int LSD_MAX = cvc_pkg::LSD_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        standalone_strap_n,
  input  wire logic        host_mode_strap,
  input  wire logic        primary_strap_n,
  input  wire logic        load_trigger_n,
  input  wire logic [1:0]  coef_set,
  output logic      [4:0]  eprom_addr,
  input  wire logic        register_load_select_in,
  output logic             register_load_select_out,
  output logic             register_load_select_oe,
  input  wire logic        host_strobe,
  input  wire logic        host_rw,
  input  wire logic [2:0]  host_addr,
  input  wire logic [7:0]  host_data_bus_in,
  output logic      [7:0]  host_data_bus_out,
  output logic             host_data_bus_oe,
  input  wire logic        chain_in,
  output logic             reply_chain_out,
  input  wire logic        first_delay_bypass,
  input  wire logic        pixel_valid,
  output logic             pixel_ready,
  input  wire logic [7:0]  field_pixel_in,
  input  wire logic [7:0]  live_pixel_in,
  input  wire logic [31:0] expansion_in,
  output logic             result_valid,
  input  wire logic        result_ready,
  output logic [15:0]      result_out,
  output logic             overflow_flag,
  output cvc_pkg::cvc_cfg_t cfg,
  output logic             is_primary
);
  initial begin
    if (LSD_MAX != cvc_pkg::LSD_DEPTH) $error("cvc_top line-store delay depth must be 12");
  end
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_ACK  = 3'b100
  } cvc_state_t;
  typedef struct packed {
    cvc_state_t                         st;
    logic [2:0]                         idx;
    logic [3:0]                         wait_cnt;
    logic [3:0][7:0]                    regs;
    logic [3:0][7:0]                    coef;
    logic                               trig_q;
    logic                               strobe_q;
    logic [7:0]                         rd_data;
    logic [LSD_MAX-1:0][7:0]            lsd;
    logic [cvc_pkg::EXP_DELAY-1:0][31:0] exd;
  } cvc_top_st_t;
  cvc_top_st_t s, next_s;

  logic single, host_mode, advance, fifo_in_ready;
  logic [7:0]  route_pix, store_pix;
  logic [1:0]  lsd_code;
  logic [31:0] sum, exp_term, total;
  logic [19:0] field;
  logic [35:0] gained;
  cvc_pkg::cvc_result_t res_in, res_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Straps and configuration fields
  assign single    = !standalone_strap_n;
  assign host_mode = host_mode_strap;
  assign is_primary = !primary_strap_n;
  assign cfg.window_mode    = s.regs[cvc_pkg::IDX_REG_A][cvc_pkg::A_MODE_LSB +: 3];
  // Cascade bits carry no meaning standalone, so they are forced to zero there
  assign cfg.cascade_bits   = single ? 4'h0 : s.regs[cvc_pkg::IDX_REG_A][3:0];
  assign cfg.gain_ext_bit   = s.regs[cvc_pkg::IDX_REG_C][3:0] != 4'h0 ? 1'b0
                              : s.regs[cvc_pkg::IDX_REG_A][cvc_pkg::A_GAINX_BIT];
  assign cfg.line_len_mode  = s.regs[cvc_pkg::IDX_REG_B][cvc_pkg::B_LEN_LSB +: 2];
  assign cfg.ext_delay_comp = s.regs[cvc_pkg::IDX_REG_B][cvc_pkg::B_EXTD_BIT];
  assign lsd_code = s.regs[cvc_pkg::IDX_REG_D][cvc_pkg::D_LSD_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////////
  // Loading port pins
  assign register_load_select_oe  = single;
  assign register_load_select_out = (s.st == ST_LOAD);
  assign eprom_addr        = {coef_set, s.idx};
  assign host_data_bus_out = s.rd_data;
  assign host_data_bus_oe  = host_mode && host_strobe && host_rw && register_load_select_in;
  assign reply_chain_out   = (s.st == ST_ACK) && (single || chain_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Pixel path
  assign route_pix = first_delay_bypass ? live_pixel_in : field_pixel_in;
  always_comb begin
    unique case (lsd_code)
      2'b00:   store_pix = route_pix;
      2'b01:   store_pix = s.lsd[cvc_pkg::LSD_STEP-1];
      2'b10:   store_pix = s.lsd[2*cvc_pkg::LSD_STEP-1];
      2'b11:   store_pix = s.lsd[3*cvc_pkg::LSD_STEP-1];
    endcase
  end
  assign sum = 32'($signed(store_pix)) * 32'($signed(s.coef[0]));
  // Pixel is 8 bits, so an 8-place shift never loses bits of the 32-bit sum
  assign exp_term = s.regs[cvc_pkg::IDX_REG_D][cvc_pkg::D_EXPD_BIT]
                    ? s.exd[cvc_pkg::EXP_DELAY-1] : expansion_in;
  assign total = (s.regs[cvc_pkg::IDX_REG_D][cvc_pkg::D_SHIFT_BIT]
                 ? (sum << cvc_pkg::SUM_SHIFT) : sum) + exp_term;
  assign field = s.regs[cvc_pkg::IDX_REG_C][cvc_pkg::C_FIELD_LSB]
                 ? total[cvc_pkg::FIELD_STEP +: cvc_pkg::FIELD_W] : total[0 +: cvc_pkg::FIELD_W];
  assign gained = {{16{field[19]}}, field} << s.regs[cvc_pkg::IDX_REG_C][cvc_pkg::C_GAIN_LSB +: 4];
  assign res_in.data = gained[19 -: cvc_pkg::RESULT_W];
  assign res_in.ovf  = (gained[35:19] != {17{gained[19]}});
  assign advance     = pixel_valid && fifo_in_ready;
  assign pixel_ready = fifo_in_ready;

  cvc_fifo #(
    .WIDTH (cvc_pkg::RESULT_W + 1),
    .DEPTH (cvc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_valid  (pixel_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (res_in),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (res_out)
  );
  assign result_out    = res_out.data;
  assign overflow_flag = res_out.ovf && result_valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and registers
  always_comb begin
    next_s          = s;
    next_s.trig_q   = load_trigger_n;
    next_s.strobe_q = host_strobe;
    if (advance) begin
      next_s.lsd = {s.lsd[LSD_MAX-2:0], route_pix};
      next_s.exd = {s.exd[cvc_pkg::EXP_DELAY-2:0], expansion_in};
    end
    unique case (s.st)
      ST_IDLE: begin
        if (!host_mode && s.trig_q && !load_trigger_n) begin
          next_s.st       = ST_LOAD;
          next_s.idx      = 3'h0;
          next_s.wait_cnt = 4'h0;
        end else if (host_mode && host_strobe && !s.strobe_q && register_load_select_in) begin
          next_s.st = ST_ACK;
          if (host_rw) begin
            next_s.rd_data = host_addr[2] ? s.coef[host_addr[1:0]] : s.regs[host_addr[1:0]];
          end else if (host_addr[2]) begin
            next_s.coef[host_addr[1:0]] = host_data_bus_in;
          end else begin
            next_s.regs[host_addr[1:0]] = host_data_bus_in;
          end
        end
      end
      ST_LOAD: begin
        // Each word waits out the slow memory access time before it is taken
        if (s.wait_cnt == 4'(cvc_pkg::EPROM_WAIT_CYC - 1)) begin
          next_s.wait_cnt = 4'h0;
          if (s.idx[2]) next_s.coef[s.idx[1:0]] = host_data_bus_in;
          else next_s.regs[s.idx[1:0]] = host_data_bus_in;
          next_s.idx = s.idx + 3'h1;
          if (s.idx == 3'(cvc_pkg::LOAD_WORDS - 1)) next_s.st = ST_IDLE;
        end else begin
          next_s.wait_cnt = s.wait_cnt + 4'h1;
        end
      end
      ST_ACK: begin
        if (!host_strobe) next_s.st = ST_IDLE;
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s        <= '0;
      s.st     <= ST_LOAD;
      s.trig_q <= 1'b1;
      s.regs   <= {4{cvc_pkg::RST_REG}};
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n || !clk_en);

  AST_LOAD_SEL_OUT: assert property (single |-> (register_load_select_out == (s.st == ST_LOAD)))
    else $error("load select output does not follow load sequence");
  AST_RELOAD: assert property ((s.st == ST_IDLE) && !host_mode && s.trig_q && !load_trigger_n
                               |=> (s.st == ST_LOAD) && (s.idx == 3'h0))
    else $error("load trigger did not start reload");
  AST_LOAD_LEN: assert property ($rose(s.st == ST_LOAD) |-> (s.st == ST_LOAD) [*8])
    else $error("load sequence ended too early");
  AST_ACK_HOLD: assert property ((s.st == ST_ACK) && host_strobe |=> (s.st == ST_ACK))
    else $error("acknowledge dropped while strobe held");
  AST_ACK_TIME: assert property (host_mode && (s.st == ST_IDLE) && host_strobe && !s.strobe_q
                                 && register_load_select_in && single ##1 host_strobe
                                 |-> ##[0:2] reply_chain_out)
    else $error("reply not within maximum delay");
  AST_HOST_WR: assert property ((s.st == ST_IDLE) && host_mode && host_strobe && !s.strobe_q
                                && register_load_select_in && !host_rw && !host_addr[2]
                                |=> s.regs[$past(host_addr[1:0])] == $past(host_data_bus_in))
    else $error("host write not stored");
  AST_CASCADE_BITS: assert property (single |-> cfg.cascade_bits == 4'h0)
    else $error("cascade bits visible standalone");
  AST_LSD_FOUR: assert property (advance && lsd_code == 2'b01 ##1 advance [*4]
                                 |-> store_pix == $past(route_pix, 4))
    else $error("four clock line-store delay wrong");
  AST_EXP_DLY: assert property (s.regs[cvc_pkg::IDX_REG_D][cvc_pkg::D_EXPD_BIT] && advance
                                ##1 advance [*4] |-> exp_term == $past(expansion_in, 4))
    else $error("expansion delay wrong");
  AST_FIELD_SEL: assert property (s.regs[cvc_pkg::IDX_REG_C][5:4] == 2'b01
                                  |-> field == total[23:4])
    else $error("result field select wrong");

  COV_RELOAD: cover property ((s.st == ST_IDLE) ##1 (s.st == ST_LOAD));
  COV_HOST:   cover property ((s.st == ST_ACK) ##1 (s.st == ST_IDLE));
  COV_OVF:    cover property (overflow_flag);
  COV_FULL:   cover property (!fifo_in_ready);
endmodule : cvc_top
`default_nettype wire

// ===== tb/cvc_rom_model.sv
// Coefficient EPROM model on the loading port
`timescale 1ns/1ps
`default_nettype none
module cvc_rom_model (
  input  wire logic       ref_clk,
  input  wire logic       slow,
  input  wire logic [4:0] addr,
  output logic      [7:0] data
);
  logic [4:0] last = 5'h1f;
  int         cnt  = 0;
  initial data = 8'h00;
  // Address bits 4:3 pick one of four stored sets
  function automatic logic [7:0] rom_word(input logic [1:0] s, input logic [2:0] i);
    case (i)
      3'h0: return {2'h2, s, 4'ha};
      3'h1: return {4'h0, s[0], s, 1'b0};
      3'h2: return {3'h0, s[1], 2'h0, s};
      // Set 0 is a lone device; set 1 is the final device of a 16-bit pair
      3'h3: return {4'h0, s, s[0], ~s[0]};
      3'h4: return {s, 6'h15};
      default: return {5'h08, i};
    endcase
  endfunction : rom_word
  ////////////////////////////////////////////////////////////////////////////
  // Data toggles until access time passes, so an early sample shows up
  always @(posedge ref_clk) begin
    if (addr !== last) begin
      last <= addr;
      cnt  <= slow ? 6 : 2;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    data <= (addr === last && cnt == 0) ? rom_word(addr[4:3], addr[2:0]) : ~data;
  end
endmodule : cvc_rom_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the convolver cascade configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 0, reset_n = 0, clk_en = 1, standalone_strap_n = 0, host_mode_strap = 0;
  logic primary_strap_n = 0, load_trigger_n = 1, register_load_select_in = 0, chain_in = 0;
  logic host_strobe = 0, host_rw = 0, first_delay_bypass = 1, pixel_valid = 0, result_ready = 0;
  logic [1:0] coef_set = 2'h0;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_wdata = 8'h00, rom_data, field_pixel_in = 8'h00, live_pixel_in = 8'h00;
  logic [31:0] expansion_in = 32'h0000_0000;
  logic [4:0] eprom_addr;
  logic [7:0] host_data_bus_out;
  logic [15:0] result_out;
  logic register_load_select_out, register_load_select_oe, host_data_bus_oe, reply_chain_out;
  logic pixel_ready, result_valid, overflow_flag, is_primary, rom_slow = 0;
  cvc_pkg::cvc_cfg_t cfg;
  wire logic [7:0] host_data_bus_in = host_mode_strap ? host_wdata : rom_data;
  logic [7:0] regs [0:4];
  logic [7:0] phist[$], rd;
  logic [31:0] ehist[$];
  cvc_pkg::cvc_result_t expq[$];
  int seed = 32'h308d_d96b, mismatches = 0, checks_done = 0, cycles = 0;
  cvc_top #(.LSD_MAX(12)) uut (.*);
  cvc_rom_model u_rom (.ref_clk(ref_clk), .slow(rom_slow), .addr(eprom_addr), .data(rom_data));
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic chk_val(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_res(input cvc_pkg::cvc_result_t e, input cvc_pkg::cvc_result_t g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t result %h expected %h", $time, g, e);
    end
  endtask : chk_res
  // Shift, expansion add, field pick and gain, worked from the register image
  function automatic cvc_pkg::cvc_result_t expect_res(input logic [7:0] p, input logic [31:0] e);
    logic [31:0] s;
    logic [19:0] f;
    logic [35:0] g;
    s = $signed(p) * $signed(regs[4]);
    if (regs[3][1]) s = s << 8;
    s = s + e;
    f = regs[2][4] ? s[23:4] : s[19:0];
    g = {{16{f[19]}}, f} << regs[2][3:0];
    return '{ovf: !(&g[35:19] || !(|g[35:19])), data: g[19:4]};
  endfunction : expect_res
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= 20000) begin
      mismatches++;
      close_out();
    end
    if (reset_n && result_valid && result_ready) begin
      if (expq.size() == 0) chk_val(16'h0000, 16'h0001);
      else chk_res(expq.pop_front(), {overflow_flag, result_out});
    end
    if (reset_n && pixel_valid && pixel_ready) begin
      phist.push_front(first_delay_bypass ? live_pixel_in : field_pixel_in);
      ehist.push_front(expansion_in);
      expq.push_back(expect_res(phist[4 * regs[3][3:2]], regs[3][0] ? ehist[4] : ehist[0]));
      void'(phist.pop_back());
      void'(ehist.pop_back());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_load;
    int n;
    n = 0;
    while (register_load_select_out === 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk_val(16'(n >= 78 && n <= 81), 16'h0001);
    chk_val(16'(register_load_select_oe), 16'h0001);
    for (int i = 0; i < 5; i++) regs[i] = u_rom.rom_word(coef_set, 3'(i));
    chk_val(16'(cfg.window_mode), 16'(regs[0][6:4]));
    chk_val(16'(cfg.cascade_bits), 16'h0000);
    chk_val(16'(cfg.gain_ext_bit), 16'(regs[2][3:0] == 0 ? regs[0][7] : 1'b0));
    chk_val(16'({cfg.ext_delay_comp, cfg.line_len_mode}), 16'(regs[1][3:1]));
  endtask : wait_load
  task automatic do_reset;
    @(negedge ref_clk);
    reset_n = 1'b0;
    phist = {};
    ehist = {};
    expq = {};
    repeat (13) phist.push_back(8'h00);
    repeat (5) ehist.push_back(32'h0000_0000);
    repeat (3) @(negedge ref_clk);
    chk_val(16'(register_load_select_out), 16'h0001);
    chk_val(16'(eprom_addr), 16'({coef_set, 3'h0}));
    chk_val(16'(is_primary), 16'(!primary_strap_n));
    reset_n = 1'b1;
    wait_load();
  endtask : do_reset
  task automatic stream(input int n, input logic hold);
    int got;
    logic acc;
    got = 0;
    acc = 1'b1;
    while (got < n) begin
      @(negedge ref_clk);
      result_ready = hold ? 1'b0 : (($random(seed) & 3) != 0);
      if (acc) begin
        field_pixel_in = 8'($random(seed));
        live_pixel_in = 8'($random(seed));
        expansion_in = 32'($random(seed));
        first_delay_bypass = 1'($random(seed));
      end
      pixel_valid = 1'b1;
      acc = pixel_ready;
      if (acc) got++;
    end
    @(negedge ref_clk);
    pixel_valid = 1'b0;
  endtask : stream
  task automatic drain;
    int n;
    n = 0;
    result_ready = 1'b1;
    while (expq.size() != 0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    chk_val(16'(expq.size()), 16'h0000);
    chk_val(16'(result_valid), 16'h0000);
  endtask : drain
  // Refused accesses must see no reply one cycle after the strobe is raised
  task automatic host_acc(input logic rw, input logic [2:0] a, input logic [7:0] d, input logic ack);
    int n;
    n = 0;
    @(negedge ref_clk);
    host_strobe = 1'b1;
    host_rw = rw;
    host_addr = a;
    host_wdata = d;
    do begin
      @(negedge ref_clk);
      n++;
    end while (reply_chain_out !== 1'b1 && n < 4);
    chk_val(16'(n == 1), 16'(ack));
    chk_val(16'(host_data_bus_oe), 16'(rw & register_load_select_in));
    rd = host_data_bus_out;
    host_strobe = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_val(16'(reply_chain_out), 16'h0000);
  endtask : host_acc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int s = 0; s < 4; s++) begin
      coef_set = 2'(s);
      rom_slow = s[0];
      primary_strap_n = s[1];
      do_reset();
      if (s == 0) begin
        stream(8, 1'b1);
        chk_val(16'({pixel_ready, result_valid}), 16'h0001);
      end
      stream(30, 1'b0);
      drain();
      $display("test stream with set %0d done", s);
    end
    coef_set = 2'h2;
    @(negedge ref_clk);
    load_trigger_n = 1'b0;
    @(negedge ref_clk);
    chk_val(16'({register_load_select_out, eprom_addr}), 16'({1'b1, coef_set, 3'h0}));
    load_trigger_n = 1'b1;
    wait_load();
    $display("test reload done");
    host_mode_strap = 1'b1;
    register_load_select_in = 1'b1;
    host_acc(1'b0, 3'h3, 8'h0e, 1'b1);
    host_acc(1'b1, 3'h3, 8'h00, 1'b1);
    chk_val(16'(rd), 16'h000e);
    register_load_select_in = 1'b0;
    host_acc(1'b0, 3'h3, 8'h01, 1'b0);
    register_load_select_in = 1'b1;
    host_acc(1'b1, 3'h3, 8'h00, 1'b1);
    chk_val(16'(rd), 16'h000e);
    host_acc(1'b1, 3'h4, 8'h00, 1'b1);
    chk_val(16'(rd), 16'(regs[4]));
    // Frozen clock enable must swallow a strobe without reply or write
    clk_en = 1'b0;
    host_acc(1'b0, 3'h3, 8'h55, 1'b0);
    clk_en = 1'b1;
    host_acc(1'b1, 3'h3, 8'h00, 1'b1);
    chk_val(16'(rd), 16'h000e);
    standalone_strap_n = 1'b1;
    chain_in = 1'b0;
    host_acc(1'b1, 3'h0, 8'h00, 1'b0);
    chk_val(16'(cfg.cascade_bits), 16'(regs[0][3:0]));
    chk_val(16'(register_load_select_oe), 16'h0000);
    chain_in = 1'b1;
    host_acc(1'b1, 3'h0, 8'h00, 1'b1);
    chk_val(16'(rd), 16'(regs[0]));
    $display("test host access done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
